// ===== logic/uart_fmt_pkg.sv
// Purpose: shared constants and carriers for the line format and baud generator block
// Assumes: 32-bit apb, one word per register
// Notes:   offsets below are byte addresses
`default_nettype none
package uart_fmt_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  // register byte addresses
  localparam logic [11:0] OFS_DATA      = 12'h000;
  localparam logic [11:0] OFS_IER_DIVHI = 12'h004;
  localparam logic [11:0] OFS_LINE      = 12'h00c;
  localparam logic [11:0] OFS_FORMAT    = 12'h010;
  // line_format_control fields
  localparam int          LC_LEN_LO     = 0;
  localparam int          LC_LEN_HI     = 1;
  localparam int          LC_STOP       = 2;
  localparam int          LC_PAR_ON     = 3;
  localparam int          LC_PAR_EVEN   = 4;
  localparam int          LC_PAR_FIXED  = 5;
  localparam int          LC_SPACING    = 6;
  localparam int          LC_BANK       = 7;
  // reset values and divisor compare constants
  localparam logic [7:0]  LINE_RESET    = 8'h00;
  localparam logic [15:0] DIV_RESET     = 16'h0000;
  localparam logic [15:0] DIV_ZERO      = 16'h0000;
  localparam logic [15:0] DIV_ONE       = 16'h0001;
  // character format encodings
  localparam logic [3:0]  CHAR_BITS_MIN = 4'h5;
  localparam logic [1:0]  LEN_FIVE      = 2'h0;
  localparam logic [2:0]  STOP_ONE      = 3'h2;
  localparam logic [2:0]  STOP_ONE_HALF = 3'h3;
  localparam logic [2:0]  STOP_TWO      = 3'h4;

  // stop length is carried in half bit times
  typedef struct packed {
    logic [3:0] dataBits;
    logic [2:0] stopHalves;
    logic       parityOn;
    logic       parityEven;
    logic       parityFixed;
  } frame_fmt_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_rsp_t;
endpackage : uart_fmt_pkg
`default_nettype wire

// ===== logic/uart_line_format_baud_gen.sv
// Purpose: line format control, divisor latches and 16x baud tick for a serial element
// Assumes: transmitter, receiver and interrupt enable logic sit outside on this clock
// Notes:   apb slave with zero wait states while ce is high
//
// What this block does
// - two low control bits pick five, six, seven or eight data bits
// - stop control bit clear gives one stop bit
// - stop bit set with five-bit characters gives one and a half stop bits
// - stop bit set with six to eight bit characters gives two stop bits
// - parity enable bit 3 adds a parity bit after the data bits
// - bit 4 low selects odd parity, high selects even parity
// - stick parity bit 5 sends and expects the inverse of bit 4
// - break bit 6 holds the serial output low until cleared
// - bank select high maps the low addresses onto the divisor latches
// - bank select low maps them onto receive, transmit and interrupt enable
// - divisor may be anything from one to 65535
// - generator output runs at sixteen times the baud rate
// - divisor is sixteen bits held in low and high byte latches
// - writing either latch byte reloads the baud counter at once
//
// Chosen here: the register offsets and register access over APB.
`default_nettype none
module uart_line_format_baud_gen
  import uart_fmt_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire uart_fmt_pkg::apb_req_t apbReq,
  output uart_fmt_pkg::apb_rsp_t    apbRsp,
  input  wire logic [7:0]           rxBufData,
  input  wire logic [7:0]           ierData,
  output logic                      rxBufReadStb,
  output logic                      txHoldWriteStb,
  output logic                      ierWriteStb,
  output logic [7:0]                hostWriteData,
  input  wire logic                 txLine,
  output logic                      serialTxPin,
  output logic                      tick16,
  output uart_fmt_pkg::frame_fmt_t  frameFmt,
  input  wire logic [7:0]           txChar,
  output logic                      txParity,
  input  wire logic [7:0]           rxChar,
  input  wire logic                 rxParityBit,
  output logic                      rxParityErr
);
  import uart_fmt_pkg::*;

  logic [7:0]  lineCtl_r;
  logic [15:0] divisor_r;
  logic [15:0] divNxt;
  logic [15:0] baudCount_r;
  logic [31:0] prdata_r;
  logic        setupPhase;
  logic        accessDone;
  logic        wrDone;
  logic        bankHigh;
  logic        mapped;
  logic        divWrite;
  logic [7:0]  wrByte;
  logic [7:0]  txMasked;
  logic [7:0]  rxMasked;
  logic        txWant;
  logic        rxWant;

  assign bankHigh   = lineCtl_r[LC_BANK];
  // a stalled clock enable stretches the access phase so no write is lost
  assign setupPhase = ce && apbReq.psel && !apbReq.penable;
  assign accessDone = ce && apbReq.psel && apbReq.penable;
  assign wrDone     = accessDone && apbReq.pwrite;
  assign wrByte     = apbReq.pwdata[7:0];
  assign mapped     = (apbReq.paddr == OFS_DATA) || (apbReq.paddr == OFS_IER_DIVHI)
                   || (apbReq.paddr == OFS_LINE) || (apbReq.paddr == OFS_FORMAT);

  assign apbRsp.pready  = ce;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
  assign apbRsp.prdata  = prdata_r;

  // line format control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lineCtl_r <= LINE_RESET;
    end else if (wrDone && apbReq.paddr == OFS_LINE) begin
      lineCtl_r <= wrByte;
    end
  end

  always_comb begin
    divNxt   = divisor_r;
    divWrite = 1'b0;
    if (wrDone && bankHigh && apbReq.paddr == OFS_DATA) begin
      divNxt[7:0] = wrByte;
      divWrite    = 1'b1;
    end
    if (wrDone && bankHigh && apbReq.paddr == OFS_IER_DIVHI) begin
      divNxt[15:8] = wrByte;
      divWrite     = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divisor_r <= DIV_RESET;
    end else begin
      divisor_r <= divNxt;
    end
  end

  // normal bank strobes, one cycle after the access edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txHoldWriteStb <= 1'b0;
      ierWriteStb    <= 1'b0;
      rxBufReadStb   <= 1'b0;
      hostWriteData  <= 8'h00;
    end else if (ce) begin
      txHoldWriteStb <= wrDone && !bankHigh && apbReq.paddr == OFS_DATA;
      ierWriteStb    <= wrDone && !bankHigh && apbReq.paddr == OFS_IER_DIVHI;
      rxBufReadStb   <= accessDone && !apbReq.pwrite && !bankHigh
                        && apbReq.paddr == OFS_DATA;
      if (wrDone) begin
        hostWriteData <= wrByte;
      end
    end
  end

  // read data captured in the setup cycle, steady through the access phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_r <= '0;
    end else if (setupPhase && !apbReq.pwrite) begin
      prdata_r <= '0;
      case (apbReq.paddr)
        OFS_DATA:      prdata_r[7:0] <= bankHigh ? divisor_r[7:0] : rxBufData;
        OFS_IER_DIVHI: prdata_r[7:0] <= bankHigh ? divisor_r[15:8] : ierData;
        OFS_LINE:      prdata_r[7:0] <= lineCtl_r;
        OFS_FORMAT:    prdata_r[$bits(frame_fmt_t)-1:0] <= frameFmt;
        default:       prdata_r <= '0;
      endcase
    end
  end

  // decoded frame format, registered so the shifters see clean levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frameFmt <= '{dataBits: CHAR_BITS_MIN, stopHalves: STOP_ONE, default: 1'b0};
    end else if (ce) begin
      frameFmt.dataBits <= CHAR_BITS_MIN + {2'b00, lineCtl_r[LC_LEN_HI:LC_LEN_LO]};
      if (!lineCtl_r[LC_STOP]) begin
        frameFmt.stopHalves <= STOP_ONE;
      end else if (lineCtl_r[LC_LEN_HI:LC_LEN_LO] == LEN_FIVE) begin
        frameFmt.stopHalves <= STOP_ONE_HALF;
      end else begin
        frameFmt.stopHalves <= STOP_TWO;
      end
      // parity slot present only when enabled
      frameFmt.parityOn    <= lineCtl_r[LC_PAR_ON];
      frameFmt.parityEven  <= lineCtl_r[LC_PAR_EVEN];
      frameFmt.parityFixed <= lineCtl_r[LC_PAR_FIXED];
    end
  end

  // data bits beyond the selected length take no part in parity
  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign txMasked[i] = txChar[i] && (4'(i) < frameFmt.dataBits);
    assign rxMasked[i] = rxChar[i] && (4'(i) < frameFmt.dataBits);
  end

  // stick parity overrides the computed bit
  always_comb begin
    txWant = frameFmt.parityEven ? ^txMasked : ~^txMasked;
    rxWant = frameFmt.parityEven ? ^rxMasked : ~^rxMasked;
    if (frameFmt.parityFixed) begin
      txWant = ~frameFmt.parityEven;
      rxWant = ~frameFmt.parityEven;
    end
  end

  // parity bit for the transmitter, check for the receiver
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txParity    <= 1'b0;
      rxParityErr <= 1'b0;
    end else if (ce) begin
      txParity    <= frameFmt.parityOn && txWant;
      rxParityErr <= frameFmt.parityOn && (rxParityBit != rxWant);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serialTxPin <= 1'b1;
    end else if (ce) begin
      serialTxPin <= txLine && !lineCtl_r[LC_SPACING];
    end
  end

  // down counter, one tick per wrap; a zero divisor stays silent
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baudCount_r <= DIV_RESET;
      tick16      <= 1'b0;
    end else if (ce) begin
      tick16 <= !divWrite && baudCount_r == DIV_ONE;
      if (divWrite) begin
        baudCount_r <= divNxt;
      end else if (baudCount_r <= DIV_ONE) begin
        baudCount_r <= divisor_r;
      end else begin
        baudCount_r <= baudCount_r - DIV_ONE;
      end
    end
  end

  reload_on_write_a: assert property (@(posedge clock) disable iff (rst)
    divWrite |=> baudCount_r == $past(divNxt))
    else $error("baud counter not reloaded by latch write");

  tick_on_wrap_a: assert property (@(posedge clock) disable iff (rst)
    (ce && !divWrite && baudCount_r == DIV_ONE) |=> tick16 ##0 baudCount_r == $past(divisor_r))
    else $error("no tick or reload at counter wrap");

  // divide by one ticks every cycle
  divide_by_one_a: assert property (@(posedge clock) disable iff (rst)
    (ce && !divWrite && divisor_r == DIV_ONE && baudCount_r == DIV_ONE)[*2] |=> tick16)
    else $error("divisor one does not tick every cycle");

  zero_silent_a: assert property (@(posedge clock) disable iff (rst)
    (divisor_r == DIV_ZERO && baudCount_r == DIV_ZERO) |=> !tick16)
    else $error("tick with zero divisor");

  break_spacing_a: assert property (@(posedge clock) disable iff (rst)
    (ce && lineCtl_r[LC_SPACING]) |=> !serialTxPin)
    else $error("serial output not spacing during break");

  // one and a half stop bits
  stop_half_a: assert property (@(posedge clock) disable iff (rst)
    (ce && lineCtl_r[LC_STOP] && lineCtl_r[LC_LEN_HI:LC_LEN_LO] == LEN_FIVE)
      |=> frameFmt.stopHalves == STOP_ONE_HALF && frameFmt.dataBits == CHAR_BITS_MIN)
    else $error("five bit stop length wrong");

  stick_level_a: assert property (@(posedge clock) disable iff (rst)
    (ce && frameFmt.parityOn && frameFmt.parityFixed) |=> txParity == !$past(frameFmt.parityEven))
    else $error("stick parity level wrong");

  parity_off_a: assert property (@(posedge clock) disable iff (rst)
    (ce && !frameFmt.parityOn) |=> !txParity && !rxParityErr)
    else $error("parity active while disabled");

  // banked write reaches the latch, not the holding register
  bank_write_a: assert property (@(posedge clock) disable iff (rst)
    (wrDone && bankHigh && apbReq.paddr == OFS_DATA)
      |=> !txHoldWriteStb && divisor_r[7:0] == $past(apbReq.pwdata[7:0]))
    else $error("banked write missed divisor latch");

  // normal bank write reaches the holding register
  thr_write_a: assert property (@(posedge clock) disable iff (rst)
    (wrDone && !bankHigh && apbReq.paddr == OFS_DATA) |=> txHoldWriteStb && !$changed(divisor_r))
    else $error("normal write did not reach holding register");
endmodule : uart_line_format_baud_gen
`default_nettype wire

// ===== bench/serial_partner.sv
// Purpose: stand-in for the receive buffer and enable register beside the block
// Assumes: strobes are single-cycle pulses on the same clock
// Notes:   receive byte steps on every read so a stale read shows up
`default_nettype none
module serial_partner (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       rxBufReadStb,
  input  wire logic       ierWriteStb,
  input  wire logic [7:0] hostWriteData,
  output logic      [7:0] rxBufData,
  output logic      [7:0] ierData
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) ierData <= 8'h00;
    else if (ierWriteStb) ierData <= hostWriteData;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rxBufData <= 8'h5a;
    else if (rxBufReadStb) rxBufData <= rxBufData + 8'h01;
  end
endmodule : serial_partner
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench for line format control and baud tick
// Assumes: ce high except in the hold scenario, so the slave answers without wait states
// Notes:   one task per scenario
`default_nettype none
`define CHK(w, e, g) begin nTests++; if ((g) !== (e)) begin numErrors++; \
  $display("[FAIL] %s exp %0h got %0h", w, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_fmt_pkg::*;
  logic        clock, rst, ce, txLine, rxParityBit;
  apb_req_t    req;
  apb_rsp_t    rsp;
  frame_fmt_t  fmt;
  logic [7:0]  rxBufData, ierData, hostWriteData, txChar, rxChar;
  logic        rxBufReadStb, txHoldWriteStb, ierWriteStb, serialTxPin, tick16;
  logic        txParity, rxParityErr, er;
  logic [31:0] rd;
  int          numErrors, nTests, nTx, nTick, f, g, e;

  uart_line_format_baud_gen DUT (.clock(clock), .rst(rst), .ce(ce), .apbReq(req),
    .apbRsp(rsp), .rxBufData(rxBufData), .ierData(ierData), .rxBufReadStb(rxBufReadStb),
    .txHoldWriteStb(txHoldWriteStb), .ierWriteStb(ierWriteStb),
    .hostWriteData(hostWriteData), .txLine(txLine), .serialTxPin(serialTxPin),
    .tick16(tick16), .frameFmt(fmt), .txChar(txChar), .txParity(txParity),
    .rxChar(rxChar), .rxParityBit(rxParityBit), .rxParityErr(rxParityErr));
  serial_partner far (.clock(clock), .rst(rst), .rxBufReadStb(rxBufReadStb),
    .ierWriteStb(ierWriteStb), .hostWriteData(hostWriteData), .rxBufData(rxBufData),
    .ierData(ierData));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (txHoldWriteStb === 1'b1) nTx++;
    if (tick16 === 1'b1) nTick++;
  end

  // request held until pready is sampled high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    req.paddr <= a; req.pwrite <= w; req.pwdata <= d;
    req.psel <= 1'b1; req.penable <= 1'b0;
    @(posedge clock);
    req.penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata; er = rsp.pslverr;
    req.psel <= 1'b0; req.penable <= 1'b0;
  endtask : apb

  function automatic logic pexp(input logic [7:0] c, input logic [1:0] l,
                                input logic [2:0] p);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - l);
    if (!p[0]) return 1'b0;
    if (p[2]) return ~p[1];
    return p[1] ? ^(c & m) : ~^(c & m);
  endfunction : pexp

  // first tick edges after the call, then spacing of the next one
  task tgap;
    f = 0;
    do begin @(posedge clock); f++; end while (tick16 !== 1'b1 && f < 400);
    g = 0;
    do begin @(posedge clock); g++; end while (tick16 !== 1'b1 && g < 400);
  endtask : tgap

  task t_reset;
    apb(OFS_LINE, 1'b0, 32'h0);
    `CHK("line reset", 32'h0, rd)
    apb(OFS_FORMAT, 1'b0, 32'h0);
    `CHK("format reset", 32'h150, rd)
    `CHK("pin idle", 1'b1, serialTxPin)
    `CHK("no tick at zero divisor", 0, nTick)
  endtask : t_reset

  task t_format;
    logic [9:0] x;
    for (int l = 0; l < 64; l++) begin
      apb(OFS_LINE, 1'b1, 32'(l));
      apb(OFS_LINE, 1'b0, 32'h0);
      `CHK("line rw", 32'(l), rd)
      apb(OFS_FORMAT, 1'b0, 32'h0);
      x = {4'h5 + 4'(l[1:0]), !l[2] ? 3'h2 : (l[1:0] == 2'h0 ? 3'h3 : 3'h4),
           l[3], l[4], l[5]};
      `CHK("frame format", x >> (l[3] ? 0 : 2), rd[9:0] >> (l[3] ? 0 : 2))
      `CHK("format port", x >> (l[3] ? 0 : 2), 10'(fmt) >> (l[3] ? 0 : 2))
    end
  endtask : t_format

  task t_parity;
    logic p;
    for (int m = 0; m < 16; m++) begin
      apb(OFS_LINE, 1'b1, {26'h0, m[2:0], 1'b0, m[3], m[3]});
      // five-bit and eight-bit parity of this byte differ, so masking is seen
      p = pexp(8'hf6, {m[3], m[3]}, m[2:0]);
      @(posedge clock);
      txChar <= 8'hf6; rxChar <= 8'hf6; rxParityBit <= ~p;
      repeat (3) @(posedge clock);
      `CHK("tx parity", p, txParity)
      `CHK("rx parity wrong", m[0], rxParityErr)
      rxParityBit <= p;
      repeat (3) @(posedge clock);
      `CHK("rx parity right", 1'b0, rxParityErr)
    end
  endtask : t_parity

  task t_break;
    apb(OFS_LINE, 1'b1, 32'h40);
    repeat (3) @(posedge clock);
    `CHK("break low", 1'b0, serialTxPin)
    apb(OFS_LINE, 1'b1, 32'h0);
    repeat (3) @(posedge clock);
    `CHK("break released", 1'b1, serialTxPin)
    txLine <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("pin follows line", 1'b0, serialTxPin)
    txLine <= 1'b1;
  endtask : t_break

  task t_bank;
    apb(OFS_LINE, 1'b1, 32'h80);
    apb(OFS_DATA, 1'b1, 32'hffffff03);
    apb(OFS_IER_DIVHI, 1'b1, 32'h0);
    apb(OFS_DATA, 1'b0, 32'h0);
    `CHK("divisor low", 32'h3, rd)
    `CHK("no hold strobe", 0, nTx)
    apb(OFS_LINE, 1'b1, 32'h0);
    apb(OFS_DATA, 1'b1, 32'h41);
    #1 `CHK("hold strobe", 1'b1, txHoldWriteStb)
    apb(OFS_IER_DIVHI, 1'b1, 32'h0f);
    apb(OFS_IER_DIVHI, 1'b0, 32'h0);
    `CHK("enable reg", 32'h0f, rd)
    e = rxBufData;
    apb(OFS_DATA, 1'b0, 32'h0);
    `CHK("receive buffer", 32'(e), rd)
    repeat (2) @(posedge clock);
    `CHK("receive advanced", 8'(e + 1), rxBufData)
    apb(12'h020, 1'b0, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    apb(OFS_LINE, 1'b1, 32'h80);
    apb(OFS_DATA, 1'b0, 32'h0);
    `CHK("divisor kept", 32'h3, rd)
  endtask : t_bank

  task t_baud;
    for (int n = 1; n < 8; n += 3) begin
      apb(OFS_DATA, 1'b1, 32'(n));
      tgap;
      `CHK("tick spacing", n, g)
    end
    apb(OFS_DATA, 1'b1, 32'h5);
    apb(OFS_IER_DIVHI, 1'b1, 32'h1);
    tgap;
    `CHK("sixteen bit divisor", 261, g)
    apb(OFS_IER_DIVHI, 1'b1, 32'h0);
    tgap;
    `CHK("reload at once", 6, f)
  endtask : t_baud

  // clock enable low must freeze the counter and drop pready
  task t_hold;
    apb(OFS_DATA, 1'b1, 32'h5);
    ce <= 1'b0;
    @(posedge clock);
    e = nTick;
    repeat (20) @(posedge clock);
    `CHK("frozen ticks", e, nTick)
    `CHK("ready dropped", 1'b0, rsp.pready)
    ce <= 1'b1;
    tgap;
    `CHK("count resumes", 6, f)
  endtask : t_hold

  task stopTest;
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stopTest

  initial begin
    numErrors = 0; nTests = 0; nTx = 0; nTick = 0;
    ce = 1'b1; rst = 1'b1; req = '0; txLine = 1'b1;
    txChar = 8'h00; rxChar = 8'h00; rxParityBit = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_format;
    t_parity;
    t_break;
    t_bank;
    t_baud;
    t_hold;
    stopTest;
  end
  // watchdog sized well past the longest expected run
  initial begin
    #100000;
    numErrors++;
    stopTest;
  end
endmodule : testbench
`default_nettype wire
